// ### hdl/vcc_defines.vh
`ifndef VCC_DEFINES_VH
`define VCC_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define VCC_IDX_ENC_STD      8'h00
`define VCC_IDX_ENC_PAT      8'h01
`define VCC_IDX_TEST_SEL_A   8'h86
`define VCC_IDX_TEST_SEL_B   8'h87
`define VCC_IDX_BLANK_0      8'hDA
`define VCC_IDX_BLANK_1      8'hDB
`define VCC_IDX_BLANK_2      8'hDC
`define VCC_IDX_BLANK_3      8'hDD
`define VCC_IDX_PIN_SEL_A    8'hE4
`define VCC_IDX_PIN_SEL_B    8'hE5
`define VCC_IDX_PWR_CLK      8'hF0
`define VCC_IDX_MAIN_CLK     8'hF2
`define VCC_IDX_AUD_CLK      8'hF3
`define VCC_IDX_OUT_DIR      8'hF6
`define VCC_IDX_CAPTURE      8'hF9
`define VCC_IDX_BANK         8'hFF

// reset values
`define VCC_RST_ZERO         8'h00
`define VCC_RST_ENC_PAT      8'h08
`define VCC_RST_BLANK_0      8'h80
`define VCC_RST_BLANK_1      8'h10
`define VCC_RST_BLANK_2      8'h80
`define VCC_RST_BLANK_3      8'h10
`define VCC_RST_OUT_DIR      8'h80
`define VCC_RST_CAPTURE      8'h20

// writable bits and bits fixed at one, per register
`define VCC_WM_ALL           8'hFF
`define VCC_WM_ENC_STD       8'hEF
`define VCC_WM_ENC_PAT       8'hF3
`define VCC_FIX_ENC_PAT      8'h08
`define VCC_WM_PIN_SEL_B     8'hF0
`define VCC_WM_PWR_CLK       8'hFF
`define VCC_WM_MAIN_CLK      8'hF0
`define VCC_WM_AUD_CLK       8'h9F
`define VCC_WM_OUT_DIR       8'hBF
`define VCC_WM_CAPTURE       8'h70
`define VCC_WM_BANK          8'h01

// field positions
`define VCC_F_POL_HI         7
`define VCC_F_SRC_HI         6
`define VCC_F_SRC_HI_LO      4
`define VCC_F_POL_LO         3
`define VCC_F_SRC_LO_HI      2
`define VCC_F_MAIN_SRC       7
`define VCC_F_AADC_POL       7
`define VCC_F_ADAC_POL       4
`define VCC_F_MUX_POL        3
`define VCC_F_HIGH_RATE      7
`define VCC_F_MONO           7
`define VCC_F_PAT_SRC        6
`define VCC_F_PEDESTAL       5
`define VCC_F_FIELD_RATE     3
`define VCC_F_PHASE_ALT      2

// clock divider route codes
`define VCC_DIV_NONE         2'h0
`define VCC_DIV_BY2          2'h1
`define VCC_DIV_BY4          2'h2

// dac clock route codes
`define VCC_DAC_EXT          2'h0
`define VCC_DAC_INT          2'h1
`define VCC_DAC_PIN          2'h2

// internal pattern colours
`define VCC_PAT_BARS         3'h0
`define VCC_PAT_WHITE        3'h1
`define VCC_PAT_YELLOW       3'h2
`define VCC_PAT_CYAN         3'h3
`define VCC_PAT_GREEN        3'h4
`define VCC_PAT_RED          3'h5

`endif

// ### hdl/vcc_pin_mux.v
module vcc_pin_mux
(
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // candidate sources, selector and polarity
  input  wire [7:0] cand_i,
  input  wire [2:0] sel_i,
  input  wire       pol_i,
  // status pin
  output wire       pin_o
);

  reg pin_r;

  // registered pick so the pin never glitches on a selector write
  always @(posedge clk_i)
  begin
    if (rst_i)
      pin_r <= 1'b0;
    else
      pin_r <= cand_i[sel_i] ^ pol_i;
  end

  assign pin_o = pin_r;

endmodule // vcc_pin_mux

// ### hdl/vcc_chip_ctrl.v
// Notes on behaviour
// - blanking word bytes: Cb, Y1, Cr, Y2
// - status pin polarity: 1 inverts selected signal
// - pin 1 source decode table
// - pin 2 source decode table
// - pin 3 source decode table
// - front end and dac power down bits
// - encoder clock: external/internal, plain/inverted
// - dac clock: ext inv, ext, int inv, pin inv
// - main clock: pin 54MHz or pll 108MHz
// - decoder core clock divider and phase decode
// - audio converter clocks plain or inverted
// - decoder mux clock plain or inverted
// - audio logic clock divider and phase decode
// - high rate mode bit, resets to one
// - per port tristate, 1 is high impedance
// - capture point field, resets to two
// - bank select bit chooses bank
// - monochrome, pedestal, phase alternation options
// - encoder source: external stream or pattern
// - field rate 60 or 50 Hz
// - subcarrier frequency select code
// - pattern type decode, others colour bars
//
// The Wishbone slave port was decided locally.
`include "vcc_defines.vh"

module vcc_chip_ctrl
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // status events from the same clock domain
  input  wire        video_loss_i,
  input  wire        audio_mute_i,
  input  wire        motion_i,
  input  wire        alarm_i,
  input  wire [63:0] dec_test_i,
  // status pins
  output wire [2:0]  status_pin_o,
  // blanking insertion bytes
  output wire [7:0]  blank_cb_o,
  output wire [7:0]  blank_y1_o,
  output wire [7:0]  blank_cr_o,
  output wire [7:0]  blank_y2_o,
  // power down
  output wire [3:0]  video_frontend_powerdown_o,
  output wire        video_dac1_powerdown_o,
  output wire        video_dac2_powerdown_o,
  // clock routing
  output reg         enc_clk_internal_o,
  output reg         enc_clk_invert_o,
  output reg  [1:0]  vdac_clk_route_o,
  output reg         vdac_clk_invert_o,
  output wire        main_clk_pll_o,
  output reg  [1:0]  dec_core_div_o,
  output reg  [1:0]  dec_core_phase_o,
  output reg         dec_core_invert_o,
  output wire        audio_adc_clock_polarity_o,
  output wire        audio_dac_clock_polarity_o,
  output wire        decoder_mux_clock_polarity_o,
  output reg  [1:0]  aud_logic_div_o,
  output reg  [1:0]  aud_logic_phase_o,
  output reg         aud_logic_invert_o,
  // output port control
  output wire        high_rate_processing_mode_o,
  output wire [3:0]  video_port_tristate_o,
  output wire [2:0]  capture_point_o,
  output wire        bank_select_o,
  // encoder settings
  output wire        monochrome_output_o,
  output wire        internal_pattern_source_o,
  output wire        setup_level_add_o,
  output wire        phase_alternation_o,
  output wire        field_rate_select_o,
  output wire [1:0]  subcarrier_freq_select_o,
  output wire [1:0]  chroma_lowpass_select_o,
  output reg  [2:0]  pattern_colour_o
);

  // register storage
  reg  [7:0]  enc_std_r;
  reg  [7:0]  enc_pat_r;
  reg  [7:0]  test_sel_a_r;
  reg  [7:0]  test_sel_b_r;
  reg  [31:0] blank_r;
  reg  [7:0]  pin_sel_a_r;
  reg  [7:0]  pin_sel_b_r;
  reg  [7:0]  pwr_clk_r;
  reg  [7:0]  main_clk_r;
  reg  [7:0]  aud_clk_r;
  reg  [7:0]  out_dir_r;
  reg  [7:0]  capture_r;
  reg  [7:0]  bank_r;
  // bus answer
  reg         ack_r;
  reg  [7:0]  rd_r;
  reg  [7:0]  rd_nxt;
  reg         hit_nxt;

  wire        req;
  wire        wr_en;
  wire [7:0]  idx;
  wire        in_range;
  wire        bank1;
  wire [7:0]  wd;
  wire [23:0] cand;
  wire [4:0]  div_dec;
  wire [4:0]  aud_dec;

  // one word per register; only the low byte lane carries data
  assign idx      = wb_adr_i[9:2];
  assign in_range = (wb_adr_i[31:10] == 22'h00_0000) && (wb_adr_i[1:0] == 2'h0);
  assign req      = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_en    = req && wb_we_i && wb_sel_i[0] && in_range;
  assign wd       = wb_dat_i[7:0];
  assign bank1    = bank_r[0];

  // read mux: bank bit steers which map the index reaches
  always @*
  begin
    rd_nxt  = 8'h00;
    hit_nxt = 1'b1;
    if (idx == `VCC_IDX_BANK)
      rd_nxt = bank_r;
    else if (bank1)
    begin
      case (idx)
        `VCC_IDX_ENC_STD: rd_nxt = enc_std_r;
        `VCC_IDX_ENC_PAT: rd_nxt = enc_pat_r;
        default:          hit_nxt = 1'b0;
      endcase
    end
    else
    begin
      case (idx)
        `VCC_IDX_TEST_SEL_A: rd_nxt = test_sel_a_r;
        `VCC_IDX_TEST_SEL_B: rd_nxt = test_sel_b_r;
        `VCC_IDX_BLANK_0:    rd_nxt = blank_r[31:24];
        `VCC_IDX_BLANK_1:    rd_nxt = blank_r[23:16];
        `VCC_IDX_BLANK_2:    rd_nxt = blank_r[15:8];
        `VCC_IDX_BLANK_3:    rd_nxt = blank_r[7:0];
        `VCC_IDX_PIN_SEL_A:  rd_nxt = pin_sel_a_r;
        `VCC_IDX_PIN_SEL_B:  rd_nxt = pin_sel_b_r;
        `VCC_IDX_PWR_CLK:    rd_nxt = pwr_clk_r;
        `VCC_IDX_MAIN_CLK:   rd_nxt = main_clk_r;
        `VCC_IDX_AUD_CLK:    rd_nxt = aud_clk_r;
        `VCC_IDX_OUT_DIR:    rd_nxt = out_dir_r;
        `VCC_IDX_CAPTURE:    rd_nxt = capture_r;
        default:             hit_nxt = 1'b0;
      endcase
    end
    if (!in_range || !hit_nxt)
      rd_nxt = 8'h00;                                  // unmapped reads zero
  end

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rd_r  <= 8'h00;
    end
    else
    begin
      ack_r <= req;
      if (req)
        rd_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h00_0000, rd_r};

  // register writes; masks keep fixed bits at their printed value
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_std_r    <= `VCC_RST_ZERO;
      enc_pat_r    <= `VCC_RST_ENC_PAT;
      test_sel_a_r <= `VCC_RST_ZERO;
      test_sel_b_r <= `VCC_RST_ZERO;
      blank_r      <= {`VCC_RST_BLANK_0, `VCC_RST_BLANK_1,
                       `VCC_RST_BLANK_2, `VCC_RST_BLANK_3};
      pin_sel_a_r  <= `VCC_RST_ZERO;
      pin_sel_b_r  <= `VCC_RST_ZERO;
      pwr_clk_r    <= `VCC_RST_ZERO;
      main_clk_r   <= `VCC_RST_ZERO;
      aud_clk_r    <= `VCC_RST_ZERO;
      out_dir_r    <= `VCC_RST_OUT_DIR;
      capture_r    <= `VCC_RST_CAPTURE;
      bank_r       <= `VCC_RST_ZERO;
    end
    else if (wr_en)
    begin
      if (idx == `VCC_IDX_BANK)
        bank_r <= wd & `VCC_WM_BANK;
      else if (bank1)
      begin
        case (idx)
          `VCC_IDX_ENC_STD: enc_std_r <= wd & `VCC_WM_ENC_STD;
          `VCC_IDX_ENC_PAT: enc_pat_r <= (wd & `VCC_WM_ENC_PAT) | `VCC_FIX_ENC_PAT;
          default:          bank_r <= bank_r;
        endcase
      end
      else
      begin
        case (idx)
          `VCC_IDX_TEST_SEL_A: test_sel_a_r   <= wd;
          `VCC_IDX_TEST_SEL_B: test_sel_b_r   <= wd;
          `VCC_IDX_BLANK_0:    blank_r[31:24] <= wd;
          `VCC_IDX_BLANK_1:    blank_r[23:16] <= wd;
          `VCC_IDX_BLANK_2:    blank_r[15:8]  <= wd;
          `VCC_IDX_BLANK_3:    blank_r[7:0]   <= wd;
          `VCC_IDX_PIN_SEL_A:  pin_sel_a_r    <= wd & `VCC_WM_ALL;
          `VCC_IDX_PIN_SEL_B:  pin_sel_b_r    <= wd & `VCC_WM_PIN_SEL_B;
          `VCC_IDX_PWR_CLK:    pwr_clk_r      <= wd & `VCC_WM_PWR_CLK;
          `VCC_IDX_MAIN_CLK:   main_clk_r     <= wd & `VCC_WM_MAIN_CLK;
          `VCC_IDX_AUD_CLK:    aud_clk_r      <= wd & `VCC_WM_AUD_CLK;
          `VCC_IDX_OUT_DIR:    out_dir_r      <= wd & `VCC_WM_OUT_DIR;
          `VCC_IDX_CAPTURE:    capture_r      <= wd & `VCC_WM_CAPTURE;
          default:             bank_r         <= bank_r;
        endcase
      end
    end
  end

  // blanking word split into its four stream bytes
  assign blank_cb_o = blank_r[31:24];
  assign blank_y1_o = blank_r[23:16];
  assign blank_cr_o = blank_r[15:8];
  assign blank_y2_o = blank_r[7:0];

  // status pin candidates, eight per pin, indexed by selector code
  assign cand[7:0] = {audio_mute_i,
                      video_loss_i | audio_mute_i | motion_i | alarm_i,
                      video_loss_i | audio_mute_i | motion_i,
                      motion_i,
                      1'b0,
                      dec_test_i[{2'h0, test_sel_a_r[3:0]}],
                      video_loss_i | audio_mute_i,
                      video_loss_i};
  assign cand[15:8] = {motion_i,
                       video_loss_i | audio_mute_i | motion_i | alarm_i,
                       video_loss_i | audio_mute_i | motion_i,
                       video_loss_i,
                       dec_test_i[{2'h1, test_sel_a_r[7:4]}],
                       dec_test_i[{2'h0, test_sel_a_r[3:0]}],
                       video_loss_i | audio_mute_i,
                       audio_mute_i};
  assign cand[23:16] = {video_loss_i,
                        video_loss_i | audio_mute_i | motion_i | alarm_i,
                        video_loss_i | audio_mute_i | motion_i,
                        audio_mute_i,
                        dec_test_i[{2'h3, test_sel_b_r[7:4]}],
                        dec_test_i[{2'h2, test_sel_b_r[3:0]}],
                        video_loss_i | audio_mute_i,
                        motion_i};

  // per pin selector and polarity fields
  wire [8:0] pin_sel;
  wire [2:0] pin_pol;

  assign pin_sel = {pin_sel_b_r[`VCC_F_SRC_HI:`VCC_F_SRC_HI_LO],
                    pin_sel_a_r[`VCC_F_SRC_LO_HI:0],
                    pin_sel_a_r[`VCC_F_SRC_HI:`VCC_F_SRC_HI_LO]};
  assign pin_pol = {pin_sel_b_r[`VCC_F_POL_HI],
                    pin_sel_a_r[`VCC_F_POL_LO],
                    pin_sel_a_r[`VCC_F_POL_HI]};

  // one registered mux per status pin
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      vcc_pin_mux u_mux
      (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .cand_i (cand[gi*8 +: 8]),
        .sel_i  (pin_sel[gi*3 +: 3]),
        .pol_i  (pin_pol[gi]),
        .pin_o  (status_pin_o[gi])
      );
    end
  endgenerate

  // power down: bit 4 is channel 1, bit 7 is channel 4
  assign video_frontend_powerdown_o = pwr_clk_r[7:4];
  assign video_dac1_powerdown_o     = out_dir_r[1];
  assign video_dac2_powerdown_o     = out_dir_r[0];

  // divider route decode shared by core and audio logic clocks
  function [4:0] div_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0, 3'h1, 3'h2, 3'h3: div_decode = {`VCC_DIV_BY4, code[1:0], 1'b0};
        3'h4, 3'h5:             div_decode = {`VCC_DIV_BY2, 1'b0, code[0], 1'b0};
        3'h6:                   div_decode = {`VCC_DIV_NONE, 2'h0, 1'b0};
        default:                div_decode = {`VCC_DIV_NONE, 2'h0, 1'b1};
      endcase
    end
  endfunction

  assign div_dec = div_decode(main_clk_r[6:4]);
  assign aud_dec = div_decode(aud_clk_r[2:0]);

  // clock routing decode, registered so every output is a flop;
  // switching clocks glitch-free is left to the clock cells
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_clk_internal_o <= 1'b0;
      enc_clk_invert_o   <= 1'b0;
      vdac_clk_route_o   <= `VCC_DAC_EXT;
      vdac_clk_invert_o  <= 1'b1;
      dec_core_div_o     <= `VCC_DIV_BY4;
      dec_core_phase_o   <= 2'h0;
      dec_core_invert_o  <= 1'b0;
      aud_logic_div_o    <= `VCC_DIV_BY4;
      aud_logic_phase_o  <= 2'h0;
      aud_logic_invert_o <= 1'b0;
    end
    else
    begin
      enc_clk_internal_o <= pwr_clk_r[3];
      enc_clk_invert_o   <= pwr_clk_r[2];
      case (pwr_clk_r[1:0])
        2'h0:    vdac_clk_route_o <= `VCC_DAC_EXT;
        2'h1:    vdac_clk_route_o <= `VCC_DAC_EXT;
        2'h2:    vdac_clk_route_o <= `VCC_DAC_INT;
        default: vdac_clk_route_o <= `VCC_DAC_PIN;
      endcase
      vdac_clk_invert_o  <= (pwr_clk_r[1:0] != 2'h1);
      dec_core_div_o     <= div_dec[4:3];
      dec_core_phase_o   <= div_dec[2:1];
      dec_core_invert_o  <= div_dec[0];
      aud_logic_div_o    <= aud_dec[4:3];
      aud_logic_phase_o  <= aud_dec[2:1];
      aud_logic_invert_o <= aud_dec[0];
    end
  end

  // single bit clock controls straight from the registers
  assign main_clk_pll_o               = main_clk_r[`VCC_F_MAIN_SRC];
  assign audio_adc_clock_polarity_o   = aud_clk_r[`VCC_F_AADC_POL];
  assign audio_dac_clock_polarity_o   = aud_clk_r[`VCC_F_ADAC_POL];
  assign decoder_mux_clock_polarity_o = aud_clk_r[`VCC_F_MUX_POL];

  // output ports: bit 4 port 1, bit 2 port 2, bit 3 port 3, bit 5 port 4
  assign high_rate_processing_mode_o = out_dir_r[`VCC_F_HIGH_RATE];
  assign video_port_tristate_o = {out_dir_r[5], out_dir_r[3],
                                  out_dir_r[2], out_dir_r[4]};
  assign capture_point_o       = capture_r[6:4];
  assign bank_select_o         = bank_r[0];

  // encoder standard and pattern fields
  assign monochrome_output_o       = enc_std_r[`VCC_F_MONO];
  assign setup_level_add_o         = enc_std_r[`VCC_F_PEDESTAL];
  assign phase_alternation_o       = enc_std_r[`VCC_F_PHASE_ALT];
  assign internal_pattern_source_o = enc_std_r[`VCC_F_PAT_SRC];
  assign field_rate_select_o       = enc_std_r[`VCC_F_FIELD_RATE];
  assign subcarrier_freq_select_o  = enc_std_r[1:0];
  assign chroma_lowpass_select_o   = enc_pat_r[1:0];

  // pattern colour decode; unknown codes fall back to colour bars
  always @(posedge clk_i)
  begin
    if (rst_i)
      pattern_colour_o <= `VCC_PAT_BARS;
    else
    begin
      case (enc_pat_r[7:4])
        4'h1:       pattern_colour_o <= `VCC_PAT_WHITE;
        4'h2:       pattern_colour_o <= `VCC_PAT_YELLOW;
        4'h3:       pattern_colour_o <= `VCC_PAT_CYAN;
        4'h4:       pattern_colour_o <= `VCC_PAT_GREEN;
        4'h5, 4'h6: pattern_colour_o <= `VCC_PAT_RED;
        default:    pattern_colour_o <= `VCC_PAT_BARS;
      endcase
    end
  end

endmodule // vcc_chip_ctrl

// ### tb/vcc_chip_monitor.sv
module vcc_chip_monitor (
  // clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // register bus
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [31:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  // outputs watched
  input logic [7:0]  blank_cb_o,
  input logic        high_rate_processing_mode_o,
  input logic [3:0]  video_port_tristate_o,
  input logic [2:0]  capture_point_o,
  input logic        bank_select_o,
  input logic        monochrome_output_o,
  input logic [2:0]  status_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic       wr_t;
  logic [7:0] d_r;
  // write taken at this edge; misaligned or high addresses never land
  assign wr_t = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                wb_adr_i[31:10] == 22'h0 && wb_adr_i[1:0] == 2'h0;
  // byte written last edge, so checks one cycle on need no $past
  always_ff @(posedge clk_i)
    d_r <= wb_dat_i[7:0];
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  reset_vals_a: assert property ($fell(rst_i) |->
    high_rate_processing_mode_o && capture_point_o == 3'h2 && !bank_select_o)
    else $error("bad values after reset");
  blank_cb_a: assert property (
    wr_t && wb_adr_i[9:2] == 8'hda && !bank_select_o |=> blank_cb_o == d_r)
    else $error("blanking top byte not taken");
  bank_sel_a: assert property (
    wr_t && wb_adr_i[9:2] == 8'hff |=> bank_select_o == d_r[0])
    else $error("bank bit not taken");
  port_hiz_a: assert property (
    wr_t && wb_adr_i[9:2] == 8'hf6 && !bank_select_o |=> high_rate_processing_mode_o ==
    d_r[7] && video_port_tristate_o == {d_r[5], d_r[3], d_r[2], d_r[4]})
    else $error("port tristate mapping wrong");
  capture_a: assert property (
    wr_t && wb_adr_i[9:2] == 8'hf9 && !bank_select_o |=> capture_point_o == d_r[6:4])
    else $error("capture point not taken");
  wrong_bank_a: assert property (
    wr_t && wb_adr_i[9:2] == 8'h00 && !bank_select_o |=> $stable(monochrome_output_o))
    else $error("bank one register hit from bank zero");
  cover property (wr_t && wb_adr_i[9:2] == 8'hff && wb_dat_i[0]);
  cover property (wb_ack_o && !wb_we_i);
  cover property ($rose(status_pin_o[2]));
endmodule // vcc_chip_monitor

bind vcc_chip_ctrl vcc_chip_monitor mon_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .blank_cb_o, .high_rate_processing_mode_o,
  .video_port_tristate_o, .capture_point_o, .bank_select_o, .monochrome_output_o,
  .status_pin_o);

// ### tb/vcc_host_model.sv
module vcc_host_model (
  // clock
  input  logic        clk_i,
  // wishbone master side
  output logic        wb_cyc_o,
  output logic        wb_stb_o,
  output logic        wb_we_o,
  output logic [31:0] wb_adr_o,
  output logic [3:0]  wb_sel_o,
  output logic [31:0] wb_dat_o,
  input  logic        wb_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_sel_o} = 7'h00;
    wb_adr_o = 32'h0000_0000;
    wb_dat_o = 32'h0000_0000;
  end
  // one classic cycle; request held until ack or for at most 20 cycles, then address and data are scrambled
  task automatic xfer(input logic we, input logic [7:0] ix, input logic [7:0] d,
                      input logic [3:0] sel, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_sel_o} <= {2'h3, we, sel};
    wb_adr_o <= {22'h0, ix, 2'h0};
    wb_dat_o <= {24'h0, d};
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = wb_ack_i;
    end
    {wb_cyc_o, wb_stb_o} <= 2'h0;
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask
endmodule // vcc_host_model

// ### tb/video_codec_chip_control_regs_test.sv
module video_codec_chip_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hr;
  logic        video_loss_i, audio_mute_i, motion_i, alarm_i, e_in, e_inv, v_inv, c_inv, a_inv;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic [63:0] dec_test_i;
  logic [2:0]  status_pin_o, capture_point_o, pattern_colour_o;
  logic [7:0]  cb, y1, cr, y2, t86, t87;
  logic [1:0]  v_rt, c_dv, c_ph, a_dv, a_ph, p;
  logic [4:0]  k;
  logic [6:0]  eo;
  logic [9:0]  po;
  logic [31:0] lf = 32'h0000_8b87;
  logic [7:0]  q[$];
  int          err_total, checks, i;
  // index, reset value, readback after writing all ones (host duty keeps 0xf6 bit 7 set)
  logic [7:0]  ix_t[14] = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'he4, 8'he5, 8'hf0, 8'hf2, 8'hf3,
                            8'hf6, 8'hf9, 8'h86, 8'h87, 8'hff};
  logic [7:0]  rs_t[14] = '{8'h80, 8'h10, 8'h80, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h80, 8'h20, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wm_t[14] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hff, 8'hf0, 8'h9f,
                            8'hbf, 8'h70, 8'hff, 8'hff, 8'h01};

  vcc_chip_ctrl vcc_chip_ctrl_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .video_loss_i, .audio_mute_i, .motion_i,
    .alarm_i, .dec_test_i, .status_pin_o, .blank_cb_o(cb), .blank_y1_o(y1), .blank_cr_o(cr),
    .blank_y2_o(y2), .video_frontend_powerdown_o(po[3:0]), .video_dac1_powerdown_o(po[4]),
    .video_dac2_powerdown_o(po[5]), .enc_clk_internal_o(e_in), .enc_clk_invert_o(e_inv),
    .vdac_clk_route_o(v_rt), .vdac_clk_invert_o(v_inv), .main_clk_pll_o(po[6]),
    .dec_core_div_o(c_dv), .dec_core_phase_o(c_ph), .dec_core_invert_o(c_inv),
    .audio_adc_clock_polarity_o(po[7]), .audio_dac_clock_polarity_o(po[8]),
    .decoder_mux_clock_polarity_o(po[9]), .aud_logic_div_o(a_dv), .aud_logic_phase_o(a_ph),
    .aud_logic_invert_o(a_inv), .high_rate_processing_mode_o(hr), .video_port_tristate_o(),
    .capture_point_o, .bank_select_o(), .monochrome_output_o(eo[6]),
    .internal_pattern_source_o(eo[5]), .setup_level_add_o(eo[4]),
    .phase_alternation_o(eo[2]), .field_rate_select_o(eo[3]),
    .subcarrier_freq_select_o(eo[1:0]), .chroma_lowpass_select_o(), .pattern_colour_o);

  vcc_host_model host_inst (.clk_i, .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i),
    .wb_ack_i(wb_ack_o));

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // divider route, phase, invert expected from a 3-bit clock code
  function automatic logic [4:0] dv(input logic [2:0] c);
    if (c < 3'h4)
      return {2'h2, c[1:0], 1'b0};
    if (c < 3'h6)
      return {3'h2, c[0], 1'b0};
    return {4'h0, c[0]};
  endfunction
  // status source for pin n (0..2) under code s, before polarity
  function automatic logic pm(input int n, input logic [2:0] s);
    logic lm;
    lm = video_loss_i | audio_mute_i;
    case (s)
      3'h1: return lm;
      3'h5: return lm | motion_i;
      3'h6: return lm | motion_i | alarm_i;
      3'h2: return n == 2 ? dec_test_i[32 + t87[3:0]] : dec_test_i[t86[3:0]];
      3'h3: return n == 0 ? 1'b0 : n == 1 ? dec_test_i[16 + t86[7:4]] : dec_test_i[48 + t87[7:4]];
      3'h0: return n == 0 ? video_loss_i : n == 1 ? audio_mute_i : motion_i;
      3'h4: return n == 0 ? motion_i : n == 1 ? video_loss_i : audio_mute_i;
      default: return n == 0 ? audio_mute_i : n == 1 ? motion_i : video_loss_i;
    endcase
  endfunction
  task automatic print_verdict();
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
                     input logic [3:0] s);
    logic ok;
    host_inst.xfer(w, ix, d, s, ok);
    if (!ok)
    begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    q.push_back(e);
    bus(1'b0, ix, 8'h00, 4'hf);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // read answers are matched against the oldest noted value
  always @(posedge clk_i)
    if (wb_ack_o && !wb_we_i)
      chk(wb_dat_o, {24'h0, q.pop_front()});
  // hang guard
  initial
  begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end

  initial
  begin
    rst_i = 1'b1;
    {video_loss_i, audio_mute_i, motion_i, alarm_i} = 4'h0;
    dec_test_i = 64'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({hr, capture_point_o}, 4'ha);
    chk({po, eo}, 17'h0);
    for (i = 0; i < 14; i++)
      rd(ix_t[i], rs_t[i]);
    for (i = 0; i < 13; i++)
    begin
      wr(ix_t[i], 8'hff);
      rd(ix_t[i], wm_t[i]);
    end
    // distinct bits so a swapped channel or polarity shows
    wr(8'hf0, 8'h50);
    wr(8'hf6, 8'h81);
    wr(8'hf3, 8'h88);
    chk(po, 10'h2e5);
    // lane 0 disabled: ignored but acked; unmapped reads give zero
    bus(1'b1, 8'he4, 8'h00, 4'he);
    rd(8'he4, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h00, 8'hff);
    wr(8'hff, 8'hff);
    rd(8'hff, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'he4, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hef);
    wr(8'h00, 8'ha6);
    chk(eo, 7'h56);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'hfb);
    for (k = 0; k < 16; k++)
    begin
      wr(8'h01, {k[3:0], 4'h8});
      repeat (2) @(posedge clk_i);
      chk(pattern_colour_o, (k == 5 || k == 6) ? 3'h5 : (k < 5) ? k[2:0] : 3'h0);
    end
    wr(8'hff, 8'h00);
    lf = nx(lf);
    for (i = 0; i < 4; i++)
      wr(8'hda + i[7:0], lf[31 - 8 * i -: 8]);
    chk({cb, y1, cr, y2}, lf);
    for (k = 0; k < 8; k++)
    begin
      wr(8'hf0, {4'h0, k[1:0], k[1:0]});
      wr(8'hf2, {1'b0, k[2:0], 4'h0});
      wr(8'hf3, {5'h0, k[2:0]});
      repeat (2) @(posedge clk_i);
      chk({e_in, e_inv}, k[1:0]);
      chk({v_rt, v_inv}, {(k[1:0] == 2'h3) ? 2'h2 : {1'b0, k[1]}, k[1:0] != 2'h1});
      chk({c_dv, k < 6 ? c_ph : 2'h0, c_inv}, dv(k[2:0]));
      chk({a_dv, k < 6 ? a_ph : 2'h0, a_inv}, dv(k[2:0]));
    end
    lf = nx(lf);
    t86 = lf[7:0];
    t87 = lf[15:8];
    wr(8'h86, t86);
    wr(8'h87, t87);
    // every source code at both polarities, with random events
    for (k = 0; k < 8; k++)
      for (p = 0; p < 2; p++)
      begin
        wr(8'he4, {p[0], k[2:0], p[0], k[2:0]});
        wr(8'he5, {p[0], k[2:0], 4'h0});
        repeat (4)
        begin
          lf = nx(lf);
          {video_loss_i, audio_mute_i, motion_i, alarm_i} <= lf[3:0];
          dec_test_i <= {lf, ~lf};
          repeat (2) @(posedge clk_i);
          chk(status_pin_o, {pm(2, k[2:0]), pm(1, k[2:0]), pm(0, k[2:0])} ^ {3{p[0]}});
        end
      end
    print_verdict();
  end
endmodule // video_codec_chip_control_regs_test
